// ### rtl/prom_pkg.sv
// Purpose: shared constants for the registered prom read port
// Assumes: single 100 MHz clock domain
// Notes: array contents and init word are programmed through ports
package prom_pkg;
   localparam int ADDR_W = 11;
   localparam int DATA_W = 8;
   localparam int DEPTH = 2048;
   localparam logic [7:0] INIT_WORD_BLANK = 8'h00;
   localparam logic SYNC_EN_OFF = 1'b1;
   localparam logic MODE_ASYNC = 1'b0;
   localparam logic MODE_SYNC = 1'b1;
   typedef logic [ADDR_W-1:0] addr_t;
   typedef logic [DATA_W-1:0] data_t;
endpackage

// ### rtl/prom_fuse_if.sv
// Purpose: carrier for fuse programming between top and array
// Assumes: programming happens while the device is idle
// Notes: one write port, one read port
`timescale 1ns/1ps
`default_nettype none
interface prom_fuse_if;
   import prom_pkg::*;
   logic wr_en;
   addr_t wr_addr;
   data_t wr_data;
   addr_t rd_addr;
   data_t rd_data;
   modport host (output wr_en, wr_addr, wr_data, rd_addr, input rd_data);
   modport array (input wr_en, wr_addr, wr_data, rd_addr, output rd_data);
endinterface
`default_nettype wire

// ### rtl/prom_array.sv
// Purpose: 2048 x 8 fuse array, combinational read
// Assumes: unprogrammed cells read zero
// Notes: programming only sets bits, like blowing fuses
`timescale 1ns/1ps
`default_nettype none
module prom_array (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // fuse port
   prom_fuse_if.array fuse
);
   import prom_pkg::*;
   data_t mem [DEPTH];
   assign fuse.rd_data = mem[fuse.rd_addr];
   // one-time: bits only ever go from 0 to 1
   // plain clocked always: the power-up initial block also writes mem
   always @(posedge ref_clk) begin
      if (fuse.wr_en) begin
         mem[fuse.wr_addr] <= mem[fuse.wr_addr] | fuse.wr_data;
      end
   end
   initial begin
      for (int i = 0; i < DEPTH; i++) begin
         mem[i] = INIT_WORD_BLANK;
      end
   end
endmodule
`default_nettype wire

// ### rtl/registered_prom_read_port.sv
// Purpose: read path of a registered 2k x 8 one-time programmable rom
// Assumes: address, enables and init are synchronous to ref_clk
// Notes: three-state outputs are value plus per-bit enable
// Notes: fuses (array, init word, mode) keep their value through reset_n
// Notes: init and the async enable act at the next edge, not clocklessly
// Notes on behaviour
// R1: 2048 words of 8 bits, 11-bit address, registered eight-bit output.
// R2: async mode: enable high floats outputs, low drives them, no clock.
// R3: sync mode: enable sampled each rising edge; high off, low on.
// R4: sync enable flop comes up off, outputs float until low sampled.
// R5: host sets address before edge; edge loads word into output register.
// R6: registered word holds between edges regardless of input changes.
// R7: init low loads extra word into output register at once.
// R8: extra init word reads all zeros unless programmed.
// R9: enable starts async; one-time programming fixes sync mode.
// R10: after init returns high, next edge loads addressed word again.
`timescale 1ns/1ps
`default_nettype none
module registered_prom_read_port (
   // clock and reset
   input wire logic ref_clk,
   input wire logic reset_n,
   // read port
   input wire prom_pkg::addr_t word_address,
   input wire logic async_output_enable_n,
   input wire logic sync_output_enable_n,
   input wire logic init_n,
   output prom_pkg::data_t registered_data_out,
   output logic [prom_pkg::DATA_W-1:0] data_out_oe,
   // one-time programming
   input wire logic prog_word_wr,
   input wire prom_pkg::addr_t prog_word_addr,
   input wire prom_pkg::data_t prog_word_data,
   input wire logic prog_init_wr,
   input wire logic prog_mode_sync,
   output logic sync_mode
);
   import prom_pkg::*;

   // ==========================================================
   // array
   prom_fuse_if fuse ();
   assign fuse.wr_en = prog_word_wr;
   assign fuse.wr_addr = prog_word_addr;
   assign fuse.wr_data = prog_word_data;
   assign fuse.rd_addr = word_address;
   prom_array u_array (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .fuse(fuse)
   );

   // ==========================================================
   // fuses for init word and enable mode
   data_t init_word_q;
   logic mode_q;
   // like fuses these survive reset; blank state set at power up
   // a plain clocked always here: the power-up initial block writes the
   // same variables, which an always_ff would not allow
   initial begin
      init_word_q = INIT_WORD_BLANK; // R8
      mode_q = MODE_ASYNC; // R9
   end
   always @(posedge ref_clk) begin
      if (prog_init_wr) begin
         init_word_q <= init_word_q | prog_word_data; // R8
      end
      if (prog_mode_sync) begin
         mode_q <= MODE_SYNC; // R9
      end
   end

   // ==========================================================
   // data register and output enable
   data_t data_d;
   data_t data_q;
   logic sen_q;
   logic drive_d;
   logic [DATA_W-1:0] oe_q;
   logic mode_out_q;
   logic sync_sel;
   logic async_on;
   logic sync_on;
   // init has priority; release falls back to the array word
   assign data_d = !init_n ? init_word_q : fuse.rd_data; // R7 R10
   // both enable pins are active low; the mode fuse picks one of them
   assign sync_sel = (mode_q == MODE_SYNC);
   assign async_on = !async_output_enable_n; // R2
   assign sync_on = !sen_q; // R3
   // async mode follows the pin; next-cycle flop stands in for no clock
   assign drive_d = sync_sel ? sync_on : async_on;

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         data_q <= INIT_WORD_BLANK;
         sen_q <= SYNC_EN_OFF; // R4
         mode_out_q <= MODE_ASYNC;
      end else begin
         data_q <= data_d; // R1 R5 R6
         sen_q <= sync_output_enable_n; // R3
         mode_out_q <= mode_q;
      end
   end

   // ==========================================================
   // per-pin drive enables
   // one flop per pin keeps each enable beside its output driver;
   // all share drive_d, so the pins can never disagree
   for (genvar b = 0; b < DATA_W; b++) begin : g_oe
      always_ff @(posedge ref_clk or negedge reset_n) begin
         if (!reset_n) begin
            oe_q[b] <= 1'b0; // R4
         end else begin
            oe_q[b] <= drive_d; // R2 R3
         end
      end
   end

   assign registered_data_out = data_q;
   assign data_out_oe = oe_q;
   assign sync_mode = mode_out_q;

   // ==========================================================
   // checks: data register
   // sampled reset_n in each antecedent keeps the release edge, where
   // the register is still being cleared, out of the comparisons
   a_edge_loads_word: assert property (@(posedge ref_clk) // R5
      disable iff (!reset_n)
      reset_n && init_n |=> data_q == $past(fuse.rd_data))
      else $error("word not loaded on edge");
   a_addr_change: assert property (@(posedge ref_clk) // R5
      disable iff (!reset_n)
      reset_n && init_n && $changed(word_address) |=>
      registered_data_out == $past(fuse.rd_data))
      else $error("new address not loaded");
   a_init_loads_extra: assert property (@(posedge ref_clk) // R7
      disable iff (!reset_n)
      reset_n && !init_n |=> data_q == $past(init_word_q))
      else $error("init word not loaded");
   a_init_over_addr: assert property (@(posedge ref_clk) // R7
      disable iff (!reset_n)
      reset_n && !init_n && $changed(word_address) |=>
      registered_data_out == $past(init_word_q))
      else $error("address won over init");
   a_init_held: assert property (@(posedge ref_clk) // R7
      disable iff (!reset_n)
      reset_n && !init_n ##1 reset_n && !init_n && $stable(init_word_q)
      |=> $stable(data_q))
      else $error("init word not held");
   a_init_release: assert property (@(posedge ref_clk) // R10
      disable iff (!reset_n)
      reset_n && !init_n ##1 reset_n && init_n |=>
      data_q == $past(fuse.rd_data))
      else $error("no array load after init");
   // same address, no init and no fuse write: the word must not move
   a_data_stable: assert property (@(posedge ref_clk) // R6
      disable iff (!reset_n)
      reset_n && init_n && $past(reset_n) && $past(init_n) &&
      $stable(word_address) && !$past(prog_word_wr) |=> $stable(data_q))
      else $error("data register changed spuriously");

   // ==========================================================
   // checks: output enables
   a_async_enable: assert property (@(posedge ref_clk) // R2
      disable iff (!reset_n)
      reset_n && mode_q == MODE_ASYNC |=>
      oe_q == {DATA_W{!$past(async_output_enable_n)}})
      else $error("async enable wrong");
   a_async_off: assert property (@(posedge ref_clk) // R2
      disable iff (!reset_n)
      reset_n && mode_q == MODE_ASYNC && async_output_enable_n |=>
      data_out_oe == '0)
      else $error("drove outputs with async enable high");
   a_async_drive: assert property (@(posedge ref_clk) // R2
      disable iff (!reset_n)
      reset_n && mode_q == MODE_ASYNC && !async_output_enable_n |=>
      data_out_oe == '1)
      else $error("async enable low left outputs off");
   // the sync pin lands in sen_q first, so the pins follow one edge later
   a_sync_enable: assert property (@(posedge ref_clk) // R3
      disable iff (!reset_n)
      reset_n && mode_q == MODE_SYNC ##1 reset_n && mode_q == MODE_SYNC
      |=> oe_q == {DATA_W{!$past(sync_output_enable_n, 2)}})
      else $error("sync enable wrong");
   a_sync_off: assert property (@(posedge ref_clk) // R3
      disable iff (!reset_n)
      reset_n && mode_q == MODE_SYNC && sync_output_enable_n ##1
      reset_n && mode_q == MODE_SYNC |=> data_out_oe == '0)
      else $error("drove outputs with sync enable high");
   a_sync_drive: assert property (@(posedge ref_clk) // R3
      disable iff (!reset_n)
      reset_n && mode_q == MODE_SYNC && !sync_output_enable_n ##1
      reset_n && mode_q == MODE_SYNC |=> data_out_oe == '1)
      else $error("sync enable low left outputs off");
   a_sync_hold: assert property (@(posedge ref_clk) // R6
      disable iff (!reset_n)
      reset_n && mode_q == MODE_SYNC ##1 reset_n && mode_q == MODE_SYNC &&
      $stable(sen_q) |=> $stable(oe_q))
      else $error("sync enable moved between samples");
   a_oe_uniform: assert property (@(posedge ref_clk) // R1
      disable iff (!reset_n)
      oe_q == '0 || oe_q == '1)
      else $error("outputs not enabled together");

   // ==========================================================
   // checks: reset and fuses
   a_sync_power_off: assert property (@(posedge ref_clk) // R4
      $rose(reset_n) |-> sen_q == SYNC_EN_OFF)
      else $error("sync enable not off at reset");
   a_reset_floats: assert property (@(posedge ref_clk) // R4
      !reset_n ##1 !reset_n |-> oe_q == '0 && sen_q == SYNC_EN_OFF)
      else $error("outputs driven in reset");
   a_release_floats: assert property (@(posedge ref_clk) // R4
      $rose(reset_n) |-> data_out_oe == '0)
      else $error("outputs driven at release");
   a_mode_sticky: assert property (@(posedge ref_clk) // R9
      mode_q == MODE_SYNC |=> mode_q == MODE_SYNC)
      else $error("mode fuse reverted");
   a_mode_by_prog: assert property (@(posedge ref_clk) // R9
      mode_q == MODE_ASYNC && !prog_mode_sync |=> mode_q == MODE_ASYNC)
      else $error("mode changed without programming");
   a_mode_out_lag: assert property (@(posedge ref_clk) // R9
      disable iff (!reset_n)
      reset_n |=> mode_out_q == $past(mode_q))
      else $error("mode output out of step");
   a_init_monotone: assert property (@(posedge ref_clk) // R8
      (init_word_q & $past(init_word_q)) == $past(init_word_q))
      else $error("init fuse cleared");
   a_init_by_prog: assert property (@(posedge ref_clk) // R8
      !prog_init_wr |=> $stable(init_word_q))
      else $error("init word changed without programming");
endmodule
`default_nettype wire

// ### sim/host_model.sv
// Purpose: host model driving the read port
// Assumes: one request per rising edge
// Notes: inputs change just after the edge
`timescale 1ns/1ps
`default_nettype none
module host_model (
   // clock
   input wire logic ref_clk,
   // read port
   output prom_pkg::addr_t word_address,
   output logic async_output_enable_n,
   output logic sync_output_enable_n,
   output logic init_n
);
   import prom_pkg::*;
   // ====================
   // request driver
   initial begin
      word_address = 11'h000;
      async_output_enable_n = 1'h1;
      sync_output_enable_n = SYNC_EN_OFF;
      init_n = 1'h1;
   end
   // held a whole cycle, so setup before the sampling edge is met
   task automatic drive(input addr_t a, input logic g, s, i);
      @(posedge ref_clk);
      word_address <= a;
      async_output_enable_n <= g;
      sync_output_enable_n <= s;
      init_n <= i;
   endtask
endmodule
`default_nettype wire

// ### sim/registered_prom_read_port_test.sv
// Purpose: self-checking bench of the prom read port
// Assumes: fuses blank at start
`timescale 1ns/1ps
`default_nettype none
`define check(g, e) begin samples_checked++; if ((g) !== (e)) begin \
mismatches++; $display("mismatch %0t got %h exp %h", $time, g, e); end end
module registered_prom_read_port_test;
   import prom_pkg::*;
   logic ref_clk = 1'h0, reset_n = 1'h0, sync_mode;
   logic prog_word_wr = 1'h0, prog_init_wr = 1'h0, prog_mode_sync = 1'h0;
   addr_t prog_word_addr = 11'h000, word_address;
   data_t prog_word_data = 8'h00, registered_data_out;
   logic async_output_enable_n, sync_output_enable_n, init_n;
   logic [DATA_W-1:0] data_out_oe;
   int mismatches = 0;
   int samples_checked = 0;
   always #5 ref_clk = ~ref_clk;
   host_model host_model_i (.ref_clk, .word_address, .async_output_enable_n,
      .sync_output_enable_n, .init_n);
   registered_prom_read_port registered_prom_read_port_i (.ref_clk, .reset_n,
      .word_address, .async_output_enable_n, .sync_output_enable_n, .init_n,
      .registered_data_out, .data_out_oe, .prog_word_wr, .prog_word_addr,
      .prog_word_data, .prog_init_wr, .prog_mode_sync, .sync_mode);
   // ====================
   // shared steps
   task automatic prog(input logic w, i, m, input addr_t a, input data_t d);
      @(posedge ref_clk);
      {prog_word_wr, prog_init_wr, prog_mode_sync} <= {w, i, m};
      prog_word_addr <= a;
      prog_word_data <= d;
      @(posedge ref_clk);
      {prog_word_wr, prog_init_wr, prog_mode_sync} <= 3'h0;
   endtask
   task automatic rd(input addr_t a, input logic g, s, i, input data_t d, oe);
      host_model_i.drive(a, g, s, i);
      @(posedge ref_clk);
      #1 `check(registered_data_out, d)
      `check(data_out_oe, oe)
   endtask
   task automatic give_verdict;
      $display("checked %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // ====================
   // scenarios
   task automatic async_scn;
      prog(1, 0, 0, 11'h005, 8'h3c);
      prog(1, 0, 0, 11'h006, 8'ha5);
      prog(1, 0, 0, 11'h7ff, 8'h81);
      rd(11'h005, 0, 1, 0, 8'h00, 8'hff);
      rd(11'h005, 0, 1, 1, 8'h3c, 8'hff);
      rd(11'h7ff, 0, 1, 1, 8'h81, 8'hff);
      rd(11'h006, 0, 1, 1, 8'ha5, 8'hff);
      rd(11'h006, 1, 1, 1, 8'ha5, 8'h00);
   endtask
   task automatic init_scn;
      prog(0, 1, 0, 11'h000, 8'h5a);
      rd(11'h006, 0, 1, 0, 8'h5a, 8'hff);
      rd(11'h005, 0, 1, 1, 8'h3c, 8'hff);
   endtask
   // sync enable lands one edge after it is sampled
   task automatic sync_scn;
      prog(0, 0, 1, 11'h000, 8'h00);
      rd(11'h006, 1, 0, 1, 8'ha5, 8'h00);
      #1 `check(sync_mode, MODE_SYNC)
      @(posedge ref_clk);
      #1 `check(data_out_oe, 8'hff)
      rd(11'h005, 0, 1, 1, 8'h3c, 8'hff);
      @(posedge ref_clk);
      reset_n <= 1'h0;
      rd(11'h005, 0, 1, 1, 8'h00, 8'h00);
      @(posedge ref_clk);
      reset_n <= 1'h1;
      rd(11'h005, 0, 1, 1, 8'h3c, 8'h00);
      `check(sync_mode, MODE_SYNC)
   endtask
   initial begin
      repeat (8) @(posedge ref_clk);
      `check(data_out_oe, 8'h00)
      reset_n <= 1'h1;
      async_scn();
      init_scn();
      sync_scn();
      give_verdict();
   end
   // the run needs about 43 cycles
   initial begin
      #5000;
      mismatches++;
      give_verdict();
   end
endmodule
`default_nettype wire
